/* File: hw/curtain_pkg.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: shared constants and types for the curtain reset and indication block
// Assumes: 20 MHz system clock, 8-bit AXI4-Lite byte addresses
// Notes: times are kept in ms, cycle counts are derived from the clock rate
//////////////////////////////////////////////////////////////////////////////
package curtain_pkg;

  // clock and documented times
  localparam int CLK_HZ = 20_000_000;
  localparam int RESET_MIN_MS = 250;
  localparam int RESET_MAX_MS = 2000;
  localparam int POWER_OFF_MS = 2000;
  localparam int FLASH_HALF_MS = 250;

  // derived cycle counts (all divide exactly at this rate)
  localparam int RESET_MIN_CYC = (CLK_HZ / 1000) * RESET_MIN_MS;
  localparam int RESET_MAX_CYC = (CLK_HZ / 1000) * RESET_MAX_MS;
  localparam int POWER_OFF_CYC = (CLK_HZ / 1000) * POWER_OFF_MS;
  localparam int FLASH_HALF_CYC = (CLK_HZ / 1000) * FLASH_HALF_MS;
  localparam int TIMER_W = 27;

  // indication sequencing in flash half periods
  localparam logic [2:0] PU_FLASH_STEPS = 3'h6;
  localparam logic [2:0] SCAN_SHOW_STEPS = 3'h4;
  localparam int ZONES = 8;

  // register byte addresses
  localparam logic [7:0] CONFIG_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] EVENTS_ADDR = 8'h08;

  // config fields and reset value
  localparam int CFG_LATCH_BIT = 0;
  localparam int CFG_RR_BIT = 1;
  localparam int CFG_SCAN_BIT = 2;
  localparam logic [2:0] CONFIG_RESET = 3'h0;

  // event fields
  localparam int EVT_ACCEPT = 0;
  localparam int EVT_SHORT = 1;
  localparam int EVT_LONG = 2;
  localparam int EVT_LOCKOUT = 3;
  localparam int EVT_PWRCYC = 4;
  localparam int EVT_W = 5;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {RX_POWERUP, RX_ALIGN, RX_RUN, RX_LATCHED, RX_LOCKOUT} rx_state_t;
  typedef enum logic [1:0] {TX_POWERUP, TX_RUN, TX_LOCKOUT} tx_state_t;
  typedef enum logic [2:0] {DISP_BLANK, DISP_SETTING, DISP_ERROR, DISP_COUNT, DISP_SCAN,
                            DISP_ALT} disp_kind_t;

endpackage

/* File: hw/curtain_reset_ctrl.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: reset qualification, lockout handling and indicators of a light curtain
// Assumes: beam, fault and self-test inputs come from logic on aclk
// Notes: registers over AXI4-Lite; power loss is seen on the supply_ok pin
//
// Function
// - manual reset needs closure of 0.25 s to 2 s, then reopening.
// - only a full open-closed-open sequence resets; a held switch never does.
// - closure beyond the maximum discards the attempt; state unchanged.
// - lockout forces both safety switching outputs off throughout; here only receiver lockout does, emitter lockout leaves them as they are.
// - lockout flashes status red and shows an error code.
// - internal lockout leaves only when fault clear and a valid reset or a power cycle occurs.
// - trip needs reset only after lockout; latch at power-up, latch, lockout.
// - supply off over 2 s then on clears lockout if cause gone.
// - emitter has no reset input; only a power cycle ends its lockout.
// - reset indicator steady in run, flashing while waiting for reset; here flashes only latched and clear, steady if blocked, dark in lockout.
// - status green outputs on, red off, flash red lockout, flash green reduced.
// - eight zones: green clear, red blocked, flashing green blanked.
// - display shows setting, error code, blocked beams, scan code briefly.
// - emitter status single red flash, green, flash green test, flash red lockout.
// - emitter digit shows error in lockout and scan code briefly.
// - power-up flashes scan code three times alternating with another symbol.
// - zone one shows beam synchronisation status.
// - trip mode turns outputs on automatically once self-test and beams clear.
//////////////////////////////////////////////////////////////////////////////
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
module curtain_reset_ctrl
  import curtain_pkg::*;
#(
  parameter int RESET_MIN = RESET_MIN_CYC,
  parameter int RESET_MAX = RESET_MAX_CYC,
  parameter int POWER_OFF = POWER_OFF_CYC,
  parameter int FLASH_HALF = FLASH_HALF_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // external pins
  input wire logic reset_sw_closed,
  input wire logic supply_ok,
  input wire logic test_sw_open,
  // receiver scanning logic
  input wire logic rx_selftest_pass,
  input wire logic sync_ok,
  input wire logic [ZONES-1:0] zone_blocked,
  input wire logic [ZONES-1:0] zone_blanked,
  input wire logic [7:0] blocked_beams,
  input wire logic rx_fault,
  input wire logic [7:0] rx_error_code,
  // emitter logic
  input wire logic tx_selftest_pass,
  input wire logic tx_fault,
  input wire logic [3:0] tx_error_code,
  // safety outputs
  output logic [1:0] safety_switching_outputs,
  // receiver indicators
  output logic rx_status_red,
  output logic rx_status_green,
  output logic rx_reset_ind,
  output logic [ZONES-1:0] zone_red,
  output logic [ZONES-1:0] zone_green,
  output disp_kind_t rx_disp_kind,
  output logic [7:0] rx_disp_value,
  // emitter indicators
  output logic tx_status_red,
  output logic tx_status_green,
  output disp_kind_t tx_disp_kind,
  output logic [7:0] tx_disp_value
);

  localparam logic [TIMER_W-1:0] POWER_OFF_V = TIMER_W'(POWER_OFF);
  localparam logic [TIMER_W-1:0] FLASH_LAST = TIMER_W'(FLASH_HALF - 1);

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [2:0] pin_meta_reg;
  logic [2:0] pin_sync_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_reg <= 3'h0;
      pin_sync_reg <= 3'h0;
    end else begin
      pin_meta_reg <= {reset_sw_closed, supply_ok, test_sw_open};
      pin_sync_reg <= pin_meta_reg;
    end
  end
  wire sw_closed_s = pin_sync_reg[2];
  wire supply_s = pin_sync_reg[1];
  wire test_open_s = pin_sync_reg[0];

  //////////////////////////////////////////////////////////////////////////////
  // manual reset qualifier
  logic reset_ok;
  logic reset_short;
  logic reset_long;
  logic sw_armed;
  reset_qualifier #(
    .MIN_CYC(RESET_MIN),
    .MAX_CYC(RESET_MAX),
    .W(TIMER_W)
  ) u_qual (
    .aclk(aclk),
    .aresetn(aresetn),
    .closed(sw_closed_s),
    .ok(reset_ok),
    .too_short(reset_short),
    .too_long(reset_long),
    .armed(sw_armed)
  );

  //////////////////////////////////////////////////////////////////////////////
  // timers: supply outage, flash divider, display sequencing
  logic [TIMER_W-1:0] off_cnt_reg;
  logic [TIMER_W-1:0] flash_cnt_reg;
  logic flash_reg;
  logic [2:0] pu_step_reg;
  logic [2:0] scan_left_reg;
  logic scan_prev_reg;
  logic [2:0] cfg_reg;
  wire latch_mode = cfg_reg[CFG_LATCH_BIT];
  wire rr_mode = cfg_reg[CFG_RR_BIT];
  wire scan_two = cfg_reg[CFG_SCAN_BIT];
  wire flash_tick = (flash_cnt_reg == FLASH_LAST);
  // power cycle seen when supply returns after a long outage
  wire power_cycle = supply_s & (off_cnt_reg > POWER_OFF_V);
  wire seq_done = (pu_step_reg == PU_FLASH_STEPS);
  wire scan_shown = (scan_left_reg != 3'h0);
  wire all_clear = sync_ok & (zone_blocked == '0);

  // outage counter saturates just past the limit
  always_ff @(posedge aclk) begin
    if (!aresetn || supply_s) begin
      off_cnt_reg <= '0;
    end else if (off_cnt_reg <= POWER_OFF_V) begin
      off_cnt_reg <= off_cnt_reg + 1'b1;
    end
  end

  // flash phase divider, one enable pulse per half period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_cnt_reg <= '0;
      flash_reg <= 1'b0;
    end else if (flash_tick) begin
      flash_cnt_reg <= '0;
      flash_reg <= ~flash_reg;
    end else begin
      flash_cnt_reg <= flash_cnt_reg + 1'b1;
    end
  end

  // power-up steps and brief scan code after a change
  always_ff @(posedge aclk) begin
    if (!aresetn || power_cycle) begin
      pu_step_reg <= 3'h0;
      scan_left_reg <= 3'h0;
      scan_prev_reg <= scan_two;
    end else begin
      scan_prev_reg <= scan_two;
      if (flash_tick && !seq_done) begin
        pu_step_reg <= pu_step_reg + 3'h1;
      end
      if (scan_two != scan_prev_reg) begin
        scan_left_reg <= SCAN_SHOW_STEPS;
      end else if (flash_tick && scan_shown) begin
        scan_left_reg <= scan_left_reg - 3'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // receiver and emitter state machines
  rx_state_t rx_state_reg;
  rx_state_t rx_state_next;
  tx_state_t tx_state_reg;
  tx_state_t tx_state_next;

  always_comb begin
    rx_state_next = rx_state_reg;
    if (rx_fault) begin
      rx_state_next = RX_LOCKOUT;
    // long outage restarts when the cause is gone
    end else if (power_cycle) begin
      rx_state_next = RX_POWERUP;
    end else begin
      case (rx_state_reg)
        RX_POWERUP: begin
          if (seq_done && rx_selftest_pass) rx_state_next = RX_ALIGN;
        end
        // trip runs once clear; latch waits for reset
        RX_ALIGN: begin
          if (all_clear) rx_state_next = latch_mode ? RX_LATCHED : RX_RUN;
        end
        RX_RUN: begin
          if (!all_clear) rx_state_next = latch_mode ? RX_LATCHED : RX_ALIGN;
        end
        RX_LATCHED: begin
          if (reset_ok && all_clear) rx_state_next = RX_RUN;
        end
        RX_LOCKOUT: begin
          if (reset_ok) rx_state_next = RX_ALIGN;
        end
        default: rx_state_next = RX_LOCKOUT;
      endcase
    end
  end

  always_comb begin
    tx_state_next = tx_state_reg;
    if (tx_fault) begin
      tx_state_next = TX_LOCKOUT;
    // emitter leaves lockout only by power cycle
    end else if (power_cycle) begin
      tx_state_next = TX_POWERUP;
    end else begin
      case (tx_state_reg)
        TX_POWERUP: begin
          if (seq_done && tx_selftest_pass) tx_state_next = TX_RUN;
        end
        TX_RUN: tx_state_next = TX_RUN;
        TX_LOCKOUT: tx_state_next = TX_LOCKOUT;
        default: tx_state_next = TX_LOCKOUT;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_state_reg <= RX_POWERUP;
      tx_state_reg <= TX_POWERUP;
    end else begin
      rx_state_reg <= rx_state_next;
      tx_state_reg <= tx_state_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // indicator and output values, taken from the next state
  wire rx_lock_n = (rx_state_next == RX_LOCKOUT);
  wire rx_pu_n = (rx_state_next == RX_POWERUP);
  wire pu_first = (pu_step_reg == 3'h0);
  // outputs only in run with supply present
  wire ssw_next = (rx_state_next == RX_RUN) & supply_s;
  wire rx_red_next = rx_pu_n ? pu_first : rx_lock_n ? flash_reg : ~ssw_next;
  wire rx_green_next = ssw_next & (~rr_mode | flash_reg);
  wire rx_rst_next = (rx_state_next == RX_RUN) |
                     ((rx_state_next == RX_LATCHED) & (~all_clear | flash_reg));
  // zones; zone one alone shows lost synchronisation
  wire [ZONES-1:0] zr_next = rx_lock_n ? '0 : rx_pu_n ? {ZONES{pu_first}} :
                             !sync_ok ? ZONES'(1) : zone_blocked;
  wire [ZONES-1:0] zg_next = (rx_lock_n || rx_pu_n || !sync_ok) ? '0 :
                             ~zone_blocked & ~(zone_blanked & {ZONES{~flash_reg}});
  // scan code alternating with a second symbol
  wire disp_kind_t pu_kind = pu_step_reg[0] ? DISP_ALT : DISP_SCAN;
  wire [7:0] scan_val = {7'h0, scan_two};
  // error code in lockout; setting, count or scan code
  wire disp_kind_t rxk_next = rx_pu_n ? pu_kind : rx_lock_n ? DISP_ERROR :
                              scan_shown ? DISP_SCAN : all_clear ? DISP_SETTING : DISP_COUNT;
  wire [7:0] rxv_next = (rx_pu_n || scan_shown) && !rx_lock_n ? scan_val :
                        rx_lock_n ? rx_error_code : all_clear ? {7'h0, latch_mode} :
                        blocked_beams;
  wire tx_lock_n = (tx_state_next == TX_LOCKOUT);
  wire tx_pu_n = (tx_state_next == TX_POWERUP);
  wire tx_red_next = tx_pu_n ? pu_first : tx_lock_n & flash_reg;
  wire tx_green_next = (tx_state_next == TX_RUN) & (~test_open_s | flash_reg);
  wire disp_kind_t txk_next = tx_pu_n ? pu_kind : tx_lock_n ? DISP_ERROR :
                              scan_shown ? DISP_SCAN : DISP_SETTING;
  wire [7:0] txv_next = tx_lock_n ? {4'h0, tx_error_code} :
                        (tx_pu_n || scan_shown) ? scan_val : 8'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      safety_switching_outputs <= 2'h0;
      {rx_status_red, rx_status_green, rx_reset_ind} <= 3'h0;
      {zone_red, zone_green} <= '0;
      {tx_status_red, tx_status_green} <= 2'h0;
      rx_disp_kind <= DISP_BLANK;
      tx_disp_kind <= DISP_BLANK;
      rx_disp_value <= 8'h00;
      tx_disp_value <= 8'h00;
    end else begin
      safety_switching_outputs <= {2{ssw_next}};
      {rx_status_red, rx_status_green, rx_reset_ind} <= {rx_red_next, rx_green_next,
                                                          rx_rst_next};
      {zone_red, zone_green} <= {zr_next, zg_next};
      {tx_status_red, tx_status_green} <= {tx_red_next, tx_green_next};
      rx_disp_kind <= rxk_next;
      tx_disp_kind <= txk_next;
      rx_disp_value <= rxv_next;
      tx_disp_value <= txv_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave: address and data taken together, one of each at a time
  logic [EVT_W-1:0] evt_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [1:0] bresp_reg;
  logic bvalid_reg;
  logic rvalid_reg;
  wire wr_take = awvalid & wvalid & ~bvalid_reg;
  wire rd_take = arvalid & ~rvalid_reg;
  wire wr_map = (awaddr == CONFIG_ADDR) | (awaddr == STATUS_ADDR) | (awaddr == EVENTS_ADDR);
  wire rd_map = (araddr == CONFIG_ADDR) | (araddr == STATUS_ADDR) | (araddr == EVENTS_ADDR);
  wire wr_cfg = wr_take & (awaddr == CONFIG_ADDR) & wstrb[0];
  wire wr_evt = wr_take & (awaddr == EVENTS_ADDR) & wstrb[0];
  wire lock_enter = (rx_lock_n & (rx_state_reg != RX_LOCKOUT)) |
                    (tx_lock_n & (tx_state_reg != TX_LOCKOUT));
  // new events win over a clear in the same cycle
  wire [EVT_W-1:0] evt_set = {power_cycle, lock_enter, reset_long, reset_short, reset_ok};
  wire [EVT_W-1:0] evt_next = (evt_reg & ~(wr_evt ? wdata[EVT_W-1:0] : '0)) | evt_set;
  wire [31:0] status_word = {22'h0, supply_s, sw_armed, sw_closed_s,
                             (rx_state_reg == RX_LATCHED) | (rx_state_reg == RX_LOCKOUT),
                             safety_switching_outputs[0], tx_state_reg, rx_state_reg};
  wire [31:0] rd_word = (araddr == CONFIG_ADDR) ? {29'h0, cfg_reg} :
                        (araddr == STATUS_ADDR) ? status_word :
                        (araddr == EVENTS_ADDR) ? {27'h0, evt_reg} : 32'h0;

  assign awready = wr_take;
  assign wready = wr_take;
  assign arready = ~rvalid_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;

  // register file
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_reg <= CONFIG_RESET;
      evt_reg <= '0;
    end else begin
      if (wr_cfg) cfg_reg <= wdata[2:0];
      evt_reg <= evt_next;
    end
  end

  // write response and read data channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= RESP_OKAY;
    end else begin
      if (wr_take) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid_reg <= 1'b0;
      end
      if (rd_take) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_word;
        rresp_reg <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  lockout_outputs_a: assert property (rx_state_reg == RX_LOCKOUT |->
    safety_switching_outputs == 2'h0) else $error("outputs on during lockout");
  lockout_flash_a: assert property (rx_state_reg == RX_LOCKOUT |->
    rx_status_red == $past(flash_reg) && !rx_status_green && rx_disp_kind == DISP_ERROR)
    else $error("lockout indication wrong");
  lockout_exit_a: assert property ($past(rx_state_reg) == RX_LOCKOUT &&
    rx_state_reg != RX_LOCKOUT |-> $past(reset_ok) || $past(power_cycle))
    else $error("lockout left without reset");
  latch_run_a: assert property (rx_state_reg == RX_RUN && $past(rx_state_reg) != RX_RUN
    && $past(latch_mode) |-> $past(reset_ok)) else $error("latch ran without reset");
  run_reset_ind_a: assert property (rx_state_reg == RX_RUN |-> rx_reset_ind)
    else $error("reset indicator dark in run");
  green_on_a: assert property (safety_switching_outputs[0] && !$past(rr_mode) |->
    rx_status_green && !rx_status_red) else $error("status not green with outputs on");
  sync_zone_a: assert property (rx_state_reg == RX_ALIGN && !sync_ok && !rx_fault
    && !power_cycle |=> zone_red == ZONES'(1) && zone_green == '0)
    else $error("sync zone wrong");
  trip_auto_a: assert property (rx_state_reg == RX_ALIGN && all_clear && !latch_mode
    && !rx_fault && !power_cycle |=> rx_state_reg == RX_RUN ##0 safety_switching_outputs
    == {2{$past(supply_s)}}) else $error("trip did not start");
  tx_hold_a: assert property (tx_state_reg == TX_LOCKOUT && !power_cycle |=>
    tx_state_reg == TX_LOCKOUT) else $error("emitter left lockout");

endmodule // curtain_reset_ctrl

/* File: hw/reset_qualifier.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: judges one open-closed-open cycle of the manual reset switch
// Assumes: closed is already synchronised to aclk
// Notes: the verdict is given on the cycle the switch reopens
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module reset_qualifier #(
  parameter int MIN_CYC = 5_000_000,
  parameter int MAX_CYC = 40_000_000,
  parameter int W = 27
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // switch level
  input wire logic closed,
  // verdicts as one-cycle pulses, and the armed level
  output logic ok,
  output logic too_short,
  output logic too_long,
  output logic armed
);

  localparam logic [W-1:0] MIN_V = W'(MIN_CYC);
  localparam logic [W-1:0] MAX_V = W'(MAX_CYC);

  logic [W-1:0] cnt_reg;
  logic armed_reg;
  logic closed_d_reg;
  wire release_evt = closed_d_reg & ~closed & armed_reg;

  // arm only after an open switch is seen, then time the closure
  // arm, then saturate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= '0;
      armed_reg <= 1'b0;
      closed_d_reg <= 1'b0;
    end else begin
      closed_d_reg <= closed;
      if (!closed) begin
        armed_reg <= 1'b1;
        cnt_reg <= '0;
      end else if (armed_reg && cnt_reg <= MAX_V) begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  assign ok = release_evt & (cnt_reg >= MIN_V) & (cnt_reg <= MAX_V);
  assign too_short = release_evt & (cnt_reg < MIN_V);
  assign too_long = release_evt & (cnt_reg > MAX_V);
  assign armed = armed_reg;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  window_ok_a: assert property (ok |-> cnt_reg >= MIN_V && cnt_reg <= MAX_V)
    else $error("reset accepted outside closure window");
  held_switch_a: assert property (!$past(armed_reg) |-> !ok)
    else $error("reset accepted without a prior open switch");
  long_drop_a: assert property (closed && cnt_reg > MAX_V ##1 !closed |-> !ok)
    else $error("overlong closure produced a reset");

endmodule // reset_qualifier

/* File: sim/safety_reset_and_status_indication_tb.sv */
// Purpose: self-checking bench of the reset and indication block
// Assumes: shortened counts, reset min 20, max 100, outage 50, flash 4
// Notes: reads queue their expected words, a monitor compares them
`timescale 1ns/1ps
`define CHK(nm, e, s) begin comparisons++; if ((e) !== (s)) begin err_total++; \
  $display("Error %s expected %h seen %h", nm, e, s); end end
`define WT(c) begin n = 0; while (!(c)) begin @(negedge aclk); n++; \
  if (n > 3000) begin err_total++; end_sim(); end end end
//////////////////////////////////////////////////////////////////////////////
module safety_reset_and_status_indication_tb;
  import curtain_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, go, supply_ok, st, sync_ok;
  logic rx_fault, tx_fault, awready, wready, bvalid, arready, rvalid, tx_green, rst_ind, grn, sw;
  logic [7:0] awaddr, araddr, beams, rx_err, rx_val, tx_val;
  logic tst_open;
  disp_kind_t rx_kind;
  logic [31:0] wdata, rdata;
  logic [15:0] hold;
  logic [ZONES-1:0] blk, blank, zgrn;
  logic [3:0] tx_err, ws;
  logic [1:0] bresp, rresp, so;
  logic [33:0] exp_q[$], msk_q[$];
  int err_total, comparisons, n;
  // clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic end_sim();
    if (err_total == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // bus write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
    `WT(awready)
    @(posedge aclk);
    {awvalid, wvalid} <= 2'h0;
    `WT(bvalid)
    `CHK("bresp", RESP_OKAY, bresp)
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  // bus read, expected response and data noted first
  task automatic rd(input logic [7:0] a, input logic [33:0] e, input logic [33:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    `WT(arready)
    @(posedge aclk);
    arvalid <= 1'b0;
    `WT(rvalid)
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  // one switch closure, then time for the verdict
  task automatic press(input int c);
    @(posedge aclk);
    {go, hold} <= {1'b1, 16'(c)};
    @(posedge aclk);
    go <= 1'b0;
    `WT(sw)
    `WT(!sw)
    repeat (8) @(posedge aclk);
  endtask
  // read monitor takes the oldest note
  always @(posedge aclk) begin
    if (rvalid && rready && exp_q.size() > 0) begin
      `CHK("read", exp_q[0], {rresp, rdata} & msk_q[0])
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end
  switch_model i_sw (.aclk(aclk), .go(go), .hold(hold), .closed(sw));
  curtain_reset_ctrl #(.RESET_MIN(20), .RESET_MAX(100), .POWER_OFF(50), .FLASH_HALF(4)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(ws), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .reset_sw_closed(sw),
    .supply_ok(supply_ok), .test_sw_open(tst_open), .rx_selftest_pass(st), .sync_ok(sync_ok),
    .zone_blocked(blk), .zone_blanked(blank), .blocked_beams(beams),
    .rx_fault(rx_fault), .rx_error_code(rx_err), .tx_selftest_pass(st), .tx_fault(tx_fault),
    .tx_error_code(tx_err), .safety_switching_outputs(so), .rx_status_red(),
    .rx_status_green(grn), .rx_reset_ind(rst_ind), .zone_red(), .zone_green(zgrn),
    .rx_disp_kind(rx_kind), .rx_disp_value(rx_val), .tx_status_red(),
    .tx_status_green(tx_green), .tx_disp_kind(), .tx_disp_value(tx_val));
  // main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, go, supply_ok, st, sync_ok} = '0;
    {rx_fault, tx_fault, awaddr, araddr, wdata, hold, blk, blank, tst_open} = '0;
    ws = 4'hf;
    err_total = 0;
    comparisons = 0;
    void'($urandom(73));
    rx_err = 8'($urandom);
    tx_err = 4'($urandom);
    beams = 8'($urandom);
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    {supply_ok, st, sync_ok} <= 3'h7;
    rd(CONFIG_ADDR, 34'h0, '1);
    rd(8'h0c, {RESP_SLVERR, 32'h0}, '1);
    `WT(so === 2'h3)
    `CHK("reset_ind", 1'b1, rst_ind)
    `CHK("status_green", 1'b1, grn)
    @(posedge aclk);
    rx_fault <= 1'b1;
    repeat (2) @(negedge aclk);
    `CHK("outputs", 2'h0, so)
    `CHK("rx_disp_kind", DISP_ERROR, rx_kind)
    `CHK("rx_disp_value", rx_err, rx_val)
    press(50);
    rd(STATUS_ADDR, 34'h4, 34'h7);
    rx_fault <= 1'b0;
    press(10);
    rd(EVENTS_ADDR, 34'h2, 34'h2);
    press(150);
    rd(STATUS_ADDR, 34'h4, 34'h7);
    rd(EVENTS_ADDR, 34'h4, 34'h4);
    wr(EVENTS_ADDR, 32'h1f);
    press(30 + $urandom_range(60));
    `WT(so === 2'h3)
    rd(EVENTS_ADDR, 34'h1, 34'h1);
    blank <= ZONES'($urandom_range(255, 1));
    @(negedge aclk);
    `WT(zgrn === ~blank)
    `WT(zgrn === '1)
    @(posedge aclk);
    {blank, ws, sync_ok} <= '0;
    `WT(so === 2'h0)
    @(posedge aclk);
    sync_ok <= 1'b1;
    `WT(so === 2'h3)
    wr(CONFIG_ADDR, 32'h1);
    rd(CONFIG_ADDR, 34'h0, '1);
    ws <= 4'hf;
    wr(CONFIG_ADDR, 32'h1);
    blk <= ZONES'($urandom_range(255, 1));
    `WT(so === 2'h0)
    rd(STATUS_ADDR, 34'h3, 34'h7);
    blk <= '0;
    repeat (20) @(negedge aclk);
    `CHK("outputs", 2'h0, so)
    press(60);
    `WT(so === 2'h3)
    @(posedge aclk);
    tst_open <= 1'b1;
    `WT(tx_green === 1'b0)
    `WT(tx_green === 1'b1)
    @(posedge aclk);
    {tst_open, tx_fault} <= 2'h1;
    press(60);
    @(negedge aclk);
    `CHK("tx_disp_value", {4'h0, tx_err}, tx_val)
    rd(STATUS_ADDR, 34'h10, 34'h18);
    tx_fault <= 1'b0;
    supply_ok <= 1'b0;
    repeat (60) @(posedge aclk);
    supply_ok <= 1'b1;
    `WT(tx_green === 1'b1)
    rd(EVENTS_ADDR, 34'h10, 34'h10);
    rd(STATUS_ADDR, 34'h8, 34'h18);
    wr(EVENTS_ADDR, 32'h1f);
    rd(EVENTS_ADDR, 34'h0, 34'h1f);
    end_sim();
  end
endmodule // safety_reset_and_status_indication_tb

/* File: sim/switch_model.sv */
// Purpose: normally open reset switch at the far side of the reset input
// Assumes: the bench commands one closure at a time
// Notes: the contact rests open between presses
`timescale 1ns/1ps
module switch_model (
  // clock
  input wire logic aclk,
  // press command and closure length in cycles
  input wire logic go,
  input wire logic [15:0] hold,
  // switch contact, high = closed
  output logic closed
);
  logic [15:0] cnt;
  initial begin
    closed = 1'b0;
    cnt = 16'h0;
  end
  always @(posedge aclk) begin
    if (go) begin
      closed <= 1'b1;
      cnt <= hold;
    end else if (cnt > 16'h1) begin
      cnt <= cnt - 16'h1;
    end else begin
      cnt <= 16'h0;
      closed <= 1'b0;
    end
  end
endmodule // switch_model
